// ===== logic/rpm_consts.svh
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH

// Register addresses (byte registers, 8-bit data port)
`define RPM_ADDR_PARAMS 8'h0A
`define RPM_ADDR_PAT0 8'h0D
`define RPM_ADDR_PAT1 8'h0E
`define RPM_ADDR_PAT2 8'h0F
`define RPM_ADDR_PAT3 8'h10
`define RPM_ADDR_STATUS 8'h20
`define RPM_ADDR_MASK 8'h21
`define RPM_ADDR_COUNT 8'h22

// Field positions in receiver_parameters
`define RPM_PARAM_EN_BIT 4
`define RPM_PARAM_SIZE_LO 2
`define RPM_PARAM_TOL_LO 0

// Status bits
`define RPM_STAT_MATCH_BIT 0
`define RPM_STAT_BIT_BIT 1

// Reset values
`define RPM_PARAMS_RESET 8'h00
`define RPM_PAT_RESET 8'h00
`define RPM_MASK_RESET 8'h00

`endif

// ===== logic/rpm_matcher.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rpm_consts.svh"

module rpm_matcher (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Received bit stream from the bit synchronizer (asynchronous pins)
    input wire logic rx_data,
    input wire logic rx_clk,
    // Results
    output logic pattern_match,
    output logic irq
);

    logic [7:0] receiver_parameters;
    logic [31:0] ref_pattern;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [31:0] shift_window;
    logic [7:0] match_count;
    logic [2:0] clk_sync;
    logic [1:0] data_sync;
    logic bit_strobe;
    logic [31:0] next_window;
    logic [31:0] cmp_mask;
    logic [31:0] diff;
    logic [5:0] err_count;
    logic hit;
    logic match_event;
    rpm_pkg::rpm_len_type len_sel;
    logic recog_on;
    logic [1:0] tol_sel;
    logic [31:0] lane_ref;
    logic [5:0] err_sum [0:32];
    logic [7:0] pat_byte [0:3];
    logic [3:0] wr_pat;
    logic wr_params;
    logic wr_mask;

    assign recog_on = receiver_parameters[`RPM_PARAM_EN_BIT];
    assign len_sel = rpm_pkg::rpm_len_type'(receiver_parameters[`RPM_PARAM_SIZE_LO +: 2]);
    assign tol_sel = receiver_parameters[`RPM_PARAM_TOL_LO +: 2];

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sync <= 3'h0;
            data_sync <= 2'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], rx_clk};
            data_sync <= {data_sync[0], rx_data};
        end
    end

    // Rising edge of the recovered data clock; data is stable around it
    assign bit_strobe = clk_sync[1] & ~clk_sync[2];

    // Newest bit enters at bit 0, so older bits climb toward bit 31
    assign next_window = {shift_window[30:0], data_sync[1]};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_window <= 32'h0;
        end else if (bit_strobe) begin
            shift_window <= next_window;
        end
    end

    // Lane k of the window holds the bit received k strobes ago.
    // For length N, lane N-1 meets pattern bit 31 and lane 0 meets
    // the last bit of the last byte in use.
    always_comb begin
        case (len_sel)
            rpm_pkg::RPM_LEN_8: begin
                cmp_mask = 32'h000000FF;
                lane_ref = {24'h0, ref_pattern[31:24]};
            end
            rpm_pkg::RPM_LEN_16: begin
                cmp_mask = 32'h0000FFFF;
                lane_ref = {16'h0, ref_pattern[31:16]};
            end
            rpm_pkg::RPM_LEN_24: begin
                cmp_mask = 32'h00FFFFFF;
                lane_ref = {8'h0, ref_pattern[31:8]};
            end
            rpm_pkg::RPM_LEN_32: begin
                cmp_mask = 32'hFFFFFFFF;
                lane_ref = ref_pattern;
            end
            default: begin
                cmp_mask = 32'h0;
                lane_ref = 32'h0;
            end
        endcase
    end

    // One compare lane per window bit; lanes beyond the length never count
    assign err_sum[0] = 6'h0;

    generate
        for (genvar k = 0; k < 32; k++) begin : g_lane
            assign diff[k] = cmp_mask[k] & (next_window[k] ^ lane_ref[k]);
            assign err_sum[k + 1] = err_sum[k] + {5'h0, diff[k]};
        end
    endgenerate

    // Ripple sum is slow but the bit rate leaves many clocks per bit
    assign err_count = err_sum[32];

    assign hit = err_count <= {4'h0, tol_sel};
    assign match_event = bit_strobe & recog_on & hit;

    // Result flag is refreshed on every received bit while recognition is on, and held clear while it is off
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pattern_match <= 1'b0;
        end else if (!recog_on) begin
            pattern_match <= 1'b0;
        end else if (bit_strobe) begin
            pattern_match <= hit;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_count <= 8'h0;
        end else if (match_event) begin
            match_count <= match_count + 8'h01;
        end
    end

    // Address decode for the write side
    assign wr_params = reg_wr && (reg_addr == `RPM_ADDR_PARAMS);
    assign wr_mask = reg_wr && (reg_addr == `RPM_ADDR_MASK);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            receiver_parameters <= `RPM_PARAMS_RESET;
        end else if (wr_params) begin
            receiver_parameters <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= `RPM_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask <= reg_wdata;
        end
    end

    // One storage byte per pattern register, leading byte first
    generate
        for (genvar b = 0; b < 4; b++) begin : g_pat_byte
            assign wr_pat[b] = reg_wr && (reg_addr == (`RPM_ADDR_PAT0 + 8'(b)));
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pat_byte[b] <= `RPM_PAT_RESET;
                end else if (wr_pat[b]) begin
                    pat_byte[b] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Leading byte lands on bits 31:24 whatever the length
    assign ref_pattern = {pat_byte[0], pat_byte[1], pat_byte[2], pat_byte[3]};

    // Sticky events; a new event in the read cycle survives the clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= 8'h0;
        end else begin
            if (reg_rd && reg_addr == `RPM_ADDR_STATUS) begin
                irq_status <= 8'h0;
            end
            if (match_event) begin
                irq_status[`RPM_STAT_MATCH_BIT] <= 1'b1;
            end
            if (bit_strobe) begin
                irq_status[`RPM_STAT_BIT_BIT] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `RPM_ADDR_PARAMS: reg_rdata <= receiver_parameters;
                `RPM_ADDR_PAT0: reg_rdata <= ref_pattern[31:24];
                `RPM_ADDR_PAT1: reg_rdata <= ref_pattern[23:16];
                `RPM_ADDR_PAT2: reg_rdata <= ref_pattern[15:8];
                `RPM_ADDR_PAT3: reg_rdata <= ref_pattern[7:0];
                `RPM_ADDR_STATUS: reg_rdata <= irq_status;
                `RPM_ADDR_MASK: reg_rdata <= irq_mask;
                `RPM_ADDR_COUNT: reg_rdata <= match_count;
                default: reg_rdata <= 8'h0;
            endcase
        end else begin
            reg_rdata <= 8'h0;
        end
    end

endmodule

// ===== logic/rpm_pkg.sv
package rpm_pkg;
    typedef enum logic [1:0] {
        RPM_LEN_8,
        RPM_LEN_16,
        RPM_LEN_24,
        RPM_LEN_32
    } rpm_len_type;
endpackage

// ===== testbench/rpm_assertions.sv
`timescale 1ns/1ps
module rpm_assertions (
    // Clock, reset, register port
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Bit stream and results
    input wire logic rx_data,
    input wire logic rx_clk,
    input wire logic pattern_match,
    input wire logic irq
);
    logic en;
    logic [7:0] msk;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Shadow of enable and mask, taken from the write strobes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en <= 1'b0;
            msk <= 8'h00;
        end else if (reg_wr && reg_addr == 8'h0A) begin
            en <= reg_wdata[4];
        end else if (reg_wr && reg_addr == 8'h21) begin
            msk <= reg_wdata;
        end
    end
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("rdata outside read slot");
    AST_UNMAP: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    AST_PAT_RB: assert property (reg_wr && reg_addr inside {[8'h0D:8'h10]}
        ##1 reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("pattern byte readback");
    AST_MASK_RB: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata == msk)
        else $error("mask readback");
    AST_EN_OFF: assert property (!en && !$past(en) |-> !pattern_match)
        else $error("match while off");
    AST_PM_EN: assert property ($rose(pattern_match) |-> $past(en))
        else $error("match rose while off");
    AST_IRQ_MASK: assert property (msk == 8'h00 |-> !irq)
        else $error("irq with mask clear");
    AST_PM_IRQ: assert property ($rose(pattern_match) && msk[0] |-> irq)
        else $error("match without irq");
endmodule
bind rpm_matcher rpm_assertions u_rpm_assertions (.*);

// ===== testbench/rpm_bitsrc.sv
`timescale 1ns/1ps
module rpm_bitsrc (
    // Clock
    input wire logic sys_clk,
    // Bit stream
    output logic rx_data,
    output logic rx_clk
);
    initial begin
        rx_data = 1'b0;
        rx_clk = 1'b0;
    end
    // ph is the level length in sys_clk; at least 3 keeps setup and hold
    task automatic send(input logic b, input int ph);
        @(posedge sys_clk);
        rx_data <= b;
        repeat (ph) @(posedge sys_clk);
        rx_clk <= 1'b1;
        repeat (ph) @(posedge sys_clk);
        rx_clk <= 1'b0;
        rx_data <= ~b;
    endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_data, rx_clk, pattern_match, irq;
    int error_cnt = 0, checks_done = 0;
    logic [31:0] pat = 32'h93AA93AA;
    rpm_matcher u_rpm_matcher (.*);
    rpm_bitsrc u_rpm_bitsrc (.*);
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Write strobe is dropped by the next read, so every write is read back at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic push(input logic [31:0] v, input int ph);
        for (int i = 31; i >= 0; i--) u_rpm_bitsrc.send(v[i], ph);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        logic [31:0] m;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'(8'h0D + i), pat[31 - 8 * i -: 8]);
            rd(8'(8'h0D + i), pat[31 - 8 * i -: 8]);
        end
        wr(8'h21, 8'h01);
        rd(8'h21, 8'h01);
        rd(8'h40, 8'h00);
        rd(8'h22, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(8'h0A, 8'h1C | 8'(t));
            rd(8'h0A, 8'h1C | 8'(t));
            push(pat ^ ((32'h1 << t) - 32'h1), 5);
            chk("pattern_match", 8'h01, pattern_match);
            chk("irq", 8'h01, irq);
            push(pat ^ ((32'h1 << (t + 1)) - 32'h1), 3);
            chk("pattern_match", 8'h00, pattern_match);
        end
        for (int s = 0; s < 4; s++) begin
            m = 32'hFFFFFFFF >> (24 - 8 * s);
            wr(8'h0A, 8'h10 | 8'(s << 2));
            rd(8'h0A, 8'h10 | 8'(s << 2));
            push((~pat & ~m) | ((pat >> (24 - 8 * s)) & m), 4);
            chk("pattern_match", 8'h01, pattern_match);
        end
        rd(8'h20, 8'h03);
        chk("irq", 8'h00, irq);
        wr(8'h0A, 8'h0C);
        rd(8'h0A, 8'h0C);
        push(pat, 4);
        chk("pattern_match", 8'h00, pattern_match);
        chk("irq", 8'h00, irq);
        rd(8'h20, 8'h02);
        give_verdict();
    end
endmodule
